// ### rtl/tc_pkg.sv
`default_nettype none
package tc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TOP  = 8'h04;
    localparam logic [7:0] OFF_CMP  = 8'h08;
    localparam logic [7:0] OFF_CNT  = 8'h0C;
    localparam logic [7:0] OFF_CAPT = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_IEN  = 8'h18;
    localparam logic [7:0] OFF_ICLR = 8'h1C;
    // Control field positions
    localparam int unsigned CT_MODE  = 0;
    localparam int unsigned CT_DOWN  = 2;
    localparam int unsigned CT_CAPEN = 3;
    localparam int unsigned CT_BUSEN = 4;
    localparam int unsigned CT_SRC   = 5;
    localparam int unsigned CT_PRE   = 6;
    localparam int unsigned CT_INV   = 9;
    localparam int unsigned CT_RPE   = 10;
    // Status, enable and clear bit positions
    localparam int unsigned ST_OVF = 0;
    localparam int unsigned ST_CMP = 1;
    localparam int unsigned ST_CAP = 2;
    // Preloaded values
    localparam logic [10:0] CTRL_RST = 11'h400;
    localparam logic [15:0] TOP_RST  = 16'hFFFF;
    localparam logic [15:0] CMP_RST  = 16'h8000;
    localparam logic [2:0]  IEN_RST  = 3'h0;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE  = 16'h0001;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Prescaler terminal counts: divide by 1, 8, 64, 256, 1024; codes above stop
    localparam logic [2:0] PRE_STOP = 3'h5;
    localparam logic [9:0] PRE_TC [0:4] = '{10'h000, 10'h007, 10'h03F, 10'h0FF, 10'h3FF};
    typedef enum logic [1:0] {
        MD_WDOG = 2'h0,
        MD_CTC  = 2'h1,
        MD_FPWM = 2'h2,
        MD_PFC  = 2'h3
    } mode_t;
    typedef enum logic [1:0] {
        PH_UP   = 2'b01,
        PH_DOWN = 2'b10
    } phase_t;
endpackage : tc_pkg
`default_nettype wire

// ### rtl/rise_detect.sv
`default_nettype none
module rise_detect (
    input  wire logic aclk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      rise
);
    logic s1_r, s2_r, s3_r, rise_r;
    logic s1_nxt, s2_nxt, s3_nxt, rise_nxt;

    // Two-flop synchroniser, then edge detect on the second stage
    always_comb begin
        s1_nxt   = din;
        s2_nxt   = s1_r;
        s3_nxt   = s2_r;
        rise_nxt = s2_r & ~s3_r;
        if (!rst_n) begin
            s1_nxt   = 1'b1;
            s2_nxt   = 1'b1;
            s3_nxt   = 1'b1;
            rise_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        s1_r   <= s1_nxt;
        s2_r   <= s2_nxt;
        s3_r   <= s3_nxt;
        rise_r <= rise_nxt;
    end

    assign rise = rise_r;

    rise_pulse_a: assert property (@(posedge aclk) disable iff (!rst_n)
        rise |-> $past(s2_r) && !$past(s3_r) ##1 !rise)
        else $error("edge pulse not one cycle");
endmodule : rise_detect
`default_nettype wire

// ### rtl/tick_prescaler.sv
`default_nettype none
module tick_prescaler (
    input  wire logic       aclk,
    input  wire logic       rst_n,
    input  wire logic       src_tick,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [9:0] cnt_r, cnt_nxt;
    logic       tick_r, tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!rst_n) begin
            cnt_nxt = 10'h000;
        end else if (src_tick && sel < tc_pkg::PRE_STOP) begin
            if (cnt_r >= tc_pkg::PRE_TC[sel]) begin
                cnt_nxt  = 10'h000;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = 10'(cnt_r + 10'h001);
            end
        end
    end

    always_ff @(posedge aclk) begin
        cnt_r  <= cnt_nxt;
        tick_r <= tick_nxt;
    end

    assign tick = tick_r;

    tick_src_a: assert property (@(posedge aclk) disable iff (!rst_n)
        tick |-> $past(src_tick) && $past(sel) < tc_pkg::PRE_STOP)
        else $error("tick without source tick");
endmodule : tick_prescaler
`default_nettype wire

// ### rtl/bidir_timer_counter_pwm.sv
// Notes on behaviour
// - 16-bit counter counts up or down
// - Single compare unit, PWM from count
// - Modes: watchdog, clear on match, PWMs
// - Selectable clock source through programmable prescaler
// - One static interrupt output to fabric
// - Separate wake-up signal to standby controller
// - Overflow, compare, capture each raise interrupts
// - Glitch-free PWM with adjustable period
// - Output waveform follows mode and compare
// - Registers reached by bus master
// - Runs stand-alone from preloaded control values
// - Reset pin enable preloaded, always honoured
// - Capture rising edge, synchronised, copies count
// - Capture only non-PWM and bus enabled
// - Interrupt: overflow flag, or enable/clear registers
`default_nettype none
module bidir_timer_counter_pwm (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        timer_input_clock,
    input  wire logic        timer_reset_low,
    input  wire logic        capture_trigger_in,
    output logic             timer_interrupt_out,
    output logic             wake_interrupt_out,
    output logic             compare_waveform_out,
    output logic [15:0]      count_value
);
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0]  awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt, rd_mux;
    logic        wr_en, wr_hit, rd_hit;

    logic [10:0] ctrl_r, ctrl_nxt;
    logic [15:0] top_r, top_nxt, cmp_r, cmp_nxt;
    logic [2:0]  ien_r, ien_nxt;

    logic [15:0]       cnt_r, cnt_nxt, top_act_r, top_a_nxt, cmp_act_r, cmp_a_nxt;
    tc_pkg::phase_t    ph_r, ph_nxt;
    logic              oc_r, oc_nxt;
    logic [15:0]       capt_r, capt_nxt;
    logic [2:0]        stat_r, stat_nxt, ev, clr;
    logic              irq_r, irq_nxt, wake_r, wake_nxt;
    logic              ovf_ev, cmp_ev, cap_ev, cap_ok, cap_rise, clk_rise;
    logic              trst, tick, src_tick, pwm, down, cnt_wr;
    tc_pkg::mode_t     mode;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        merge = old;
        if (s[0]) merge[7:0] = d[7:0];
        if (s[1]) merge[15:8] = d[15:8];
    endfunction : merge

    // Timer reset: bus reset or the reset pin while enabled
    assign trst = !aresetn || (ctrl_r[tc_pkg::CT_RPE] && !timer_reset_low);
    assign mode = tc_pkg::mode_t'(ctrl_r[tc_pkg::CT_MODE +: 2]);
    assign pwm  = ctrl_r[tc_pkg::CT_MODE + 1];
    assign down = ctrl_r[tc_pkg::CT_DOWN];

    // Bus slave
    assign awready = !aw_got_r;
    assign wready  = !w_got_r;
    assign arready = !rvalid_r;
    assign wr_en   = aw_got_r && w_got_r && !bvalid_r;
    assign wr_hit  = awaddr_r[1:0] == 2'h0 && awaddr_r <= tc_pkg::OFF_ICLR;
    assign rd_hit  = araddr[1:0] == 2'h0 && araddr <= tc_pkg::OFF_ICLR;
    assign cnt_wr  = wr_en && awaddr_r == tc_pkg::OFF_CNT;
    assign clr     = (wr_en && awaddr_r == tc_pkg::OFF_ICLR && wstrb_r[0]) ?
                     wdata_r[2:0] : 3'h0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (araddr)
            tc_pkg::OFF_CTRL: rd_mux[10:0] = ctrl_r;
            tc_pkg::OFF_TOP:  rd_mux[15:0] = top_r;
            tc_pkg::OFF_CMP:  rd_mux[15:0] = cmp_r;
            tc_pkg::OFF_CNT:  rd_mux[15:0] = cnt_r;
            tc_pkg::OFF_CAPT: rd_mux[15:0] = capt_r;
            tc_pkg::OFF_STAT: rd_mux[2:0]  = stat_r;
            tc_pkg::OFF_IEN:  rd_mux[2:0]  = ien_r;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        if (awvalid && awready) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = awaddr;
        end
        if (wvalid && wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = wdata;
            wstrb_nxt = wstrb;
        end
        if (wr_en) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_hit ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_mux;
            rresp_nxt  = rd_hit ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (!aresetn) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b0;
            rvalid_nxt = 1'b0;
            bresp_nxt  = tc_pkg::RESP_OKAY;
            rresp_nxt  = tc_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk) begin
        aw_got_r <= aw_got_nxt;
        w_got_r  <= w_got_nxt;
        awaddr_r <= awaddr_nxt;
        wdata_r  <= wdata_nxt;
        wstrb_r  <= wstrb_nxt;
        bvalid_r <= bvalid_nxt;
        bresp_r  <= bresp_nxt;
        rvalid_r <= rvalid_nxt;
        rresp_r  <= rresp_nxt;
        rdata_r  <= rdata_nxt;
    end

    assign bvalid = bvalid_r;
    assign bresp  = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp  = rresp_r;
    assign rdata  = rdata_r;

    // Control registers
    always_comb begin
        ctrl_nxt = ctrl_r;
        top_nxt  = top_r;
        cmp_nxt  = cmp_r;
        ien_nxt  = ien_r;
        if (trst) begin
            ctrl_nxt = tc_pkg::CTRL_RST;
            top_nxt  = tc_pkg::TOP_RST;
            cmp_nxt  = tc_pkg::CMP_RST;
            ien_nxt  = tc_pkg::IEN_RST;
        end else if (wr_en) begin
            unique case (awaddr_r)
                tc_pkg::OFF_CTRL: begin
                    ctrl_nxt = 11'(merge({5'h00, ctrl_r}, wdata_r, wstrb_r));
                    ctrl_nxt[tc_pkg::CT_RPE] = 1'b1;
                end
                tc_pkg::OFF_TOP: top_nxt = merge(top_r, wdata_r, wstrb_r);
                tc_pkg::OFF_CMP: cmp_nxt = merge(cmp_r, wdata_r, wstrb_r);
                tc_pkg::OFF_IEN: if (wstrb_r[0]) ien_nxt = wdata_r[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        ctrl_r <= ctrl_nxt;
        top_r  <= top_nxt;
        cmp_r  <= cmp_nxt;
        ien_r  <= ien_nxt;
    end

    // Clock source and prescaler
    rise_detect u_clk_edge (
        .aclk  (aclk),
        .rst_n (!trst),
        .din   (timer_input_clock),
        .rise  (clk_rise)
    );

    assign src_tick = ctrl_r[tc_pkg::CT_SRC] ? clk_rise : 1'b1;

    tick_prescaler u_pre (
        .aclk     (aclk),
        .rst_n    (!trst),
        .src_tick (src_tick),
        .sel      (ctrl_r[tc_pkg::CT_PRE +: 3]),
        .tick     (tick)
    );

    rise_detect u_cap_edge (
        .aclk  (aclk),
        .rst_n (!trst),
        .din   (capture_trigger_in),
        .rise  (cap_rise)
    );

    // Counter, compare and waveform
    always_comb begin
        cnt_nxt   = cnt_r;
        ph_nxt    = ph_r;
        top_a_nxt = pwm ? top_act_r : top_r;
        cmp_a_nxt = pwm ? cmp_act_r : cmp_r;
        oc_nxt    = oc_r;
        ovf_ev    = 1'b0;
        cmp_ev    = 1'b0;
        if (trst) begin
            cnt_nxt   = tc_pkg::CNT_ZERO;
            ph_nxt    = tc_pkg::PH_UP;
            top_a_nxt = tc_pkg::TOP_RST;
            cmp_a_nxt = tc_pkg::CMP_RST;
            oc_nxt    = 1'b0;
        end else begin
            if (cnt_wr) begin
                cnt_nxt = merge(cnt_r, wdata_r, wstrb_r);
            end else if (tick) begin
                cmp_ev = cnt_r == cmp_act_r;
                unique case (mode)
                    tc_pkg::MD_WDOG: begin
                        ovf_ev  = cnt_r == (down ? tc_pkg::CNT_ZERO : tc_pkg::CNT_MAX);
                        cnt_nxt = down ? 16'(cnt_r - 16'h0001) : 16'(cnt_r + 16'h0001);
                        oc_nxt  = ovf_ev ^ ctrl_r[tc_pkg::CT_INV];
                    end
                    tc_pkg::MD_CTC: begin
                        ovf_ev = !down && cnt_r == tc_pkg::CNT_MAX;
                        if (cnt_r == (down ? tc_pkg::CNT_ZERO : cmp_act_r)) begin
                            cmp_ev  = 1'b1;
                            oc_nxt  = !oc_r;
                            cnt_nxt = down ? cmp_act_r : tc_pkg::CNT_ZERO;
                        end else begin
                            cnt_nxt = down ? 16'(cnt_r - 16'h0001) : 16'(cnt_r + 16'h0001);
                        end
                    end
                    tc_pkg::MD_FPWM: begin
                        if (cnt_r >= top_act_r) begin
                            ovf_ev    = 1'b1;
                            cnt_nxt   = tc_pkg::CNT_ZERO;
                            top_a_nxt = top_r;
                            cmp_a_nxt = cmp_r;
                        end else begin
                            cnt_nxt = 16'(cnt_r + 16'h0001);
                        end
                    end
                    tc_pkg::MD_PFC: begin
                        unique case (ph_r)
                            tc_pkg::PH_UP: begin
                                if (cnt_r >= top_act_r) begin
                                    ph_nxt  = tc_pkg::PH_DOWN;
                                    cnt_nxt = (cnt_r == tc_pkg::CNT_ZERO) ?
                                              cnt_r : 16'(cnt_r - 16'h0001);
                                end else begin
                                    cnt_nxt = 16'(cnt_r + 16'h0001);
                                end
                            end
                            tc_pkg::PH_DOWN: begin
                                if (cnt_r == tc_pkg::CNT_ZERO) begin
                                    ovf_ev    = 1'b1;
                                    ph_nxt    = tc_pkg::PH_UP;
                                    top_a_nxt = top_r;
                                    cmp_a_nxt = cmp_r;
                                    cnt_nxt   = (top_r == tc_pkg::CNT_ZERO) ?
                                                cnt_r : tc_pkg::CNT_ONE;
                                end else begin
                                    cnt_nxt = 16'(cnt_r - 16'h0001);
                                end
                            end
                            default: ph_nxt = tc_pkg::PH_UP;
                        endcase
                    end
                endcase
            end
            if (pwm) begin
                oc_nxt = (cnt_nxt < cmp_a_nxt) ^ ctrl_r[tc_pkg::CT_INV];
            end
        end
    end

    always_ff @(posedge aclk) begin
        cnt_r     <= cnt_nxt;
        ph_r      <= ph_nxt;
        top_act_r <= top_a_nxt;
        cmp_act_r <= cmp_a_nxt;
        oc_r      <= oc_nxt;
    end

    // Capture, status and interrupts
    assign cap_ok = ctrl_r[tc_pkg::CT_CAPEN] && ctrl_r[tc_pkg::CT_BUSEN] && !pwm;
    assign cap_ev = cap_rise && cap_ok;
    assign ev     = {cap_ev, cmp_ev, ovf_ev};

    always_comb begin
        capt_nxt = cap_ev ? cnt_r : capt_r;
        stat_nxt = (stat_r & ~clr) | ev;
        irq_nxt  = ctrl_nxt[tc_pkg::CT_BUSEN] ? |(stat_nxt & ien_nxt) :
                   stat_nxt[tc_pkg::ST_OVF];
        wake_nxt = |ev;
        if (trst) begin
            capt_nxt = tc_pkg::CNT_ZERO;
            stat_nxt = 3'h0;
            irq_nxt  = 1'b0;
            wake_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        capt_r <= capt_nxt;
        stat_r <= stat_nxt;
        irq_r  <= irq_nxt;
        wake_r <= wake_nxt;
    end

    assign timer_interrupt_out  = irq_r;
    assign wake_interrupt_out   = wake_r;
    assign compare_waveform_out = oc_r;
    assign count_value          = cnt_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wdog_step_s;
        !trst && !cnt_wr && tick && mode == tc_pkg::MD_WDOG;
    endsequence
    sequence cap_hit_s;
        !trst && cap_rise && cap_ok;
    endsequence

    count_up_a: assert property (wdog_step_s and !down |=>
        cnt_r == 16'($past(cnt_r) + 16'h0001)) else $error("up count wrong");
    count_down_a: assert property (wdog_step_s and down |=>
        cnt_r == 16'($past(cnt_r) - 16'h0001)) else $error("down count wrong");
    ctc_clear_a: assert property (!trst && !cnt_wr && tick && mode == tc_pkg::MD_CTC
        && !down && cnt_r == cmp_act_r |=> cnt_r == tc_pkg::CNT_ZERO && oc_r != $past(oc_r))
        else $error("clear on match failed");
    pwm_reload_a: assert property (!trst && !cnt_wr && tick && mode == tc_pkg::MD_FPWM
        && cnt_r >= top_act_r |=> cnt_r == tc_pkg::CNT_ZERO && stat_r[tc_pkg::ST_OVF]
        && cmp_act_r == $past(cmp_r)) else $error("fast pwm reload failed");
    pwm_level_a: assert property (!trst && pwm |=>
        oc_r == ((cnt_r < cmp_act_r) ^ $past(ctrl_r[tc_pkg::CT_INV])))
        else $error("pwm level wrong");
    capture_take_a: assert property (cap_hit_s |=> capt_r == $past(cnt_r)
        ##0 stat_r[tc_pkg::ST_CAP]) else $error("capture missed");
    capture_block_a: assert property (!trst && pwm |=> $stable(capt_r))
        else $error("capture in pwm mode");
    irq_route_a: assert property (irq_r == (ctrl_r[tc_pkg::CT_BUSEN] ?
        |(stat_r & ien_r) : stat_r[tc_pkg::ST_OVF])) else $error("interrupt routing wrong");
    sticky_set_a: assert property (!trst && ovf_ev |=> stat_r[tc_pkg::ST_OVF]
        ##1 (stat_r[tc_pkg::ST_OVF] || $past(clr[tc_pkg::ST_OVF]) || $past(trst)))
        else $error("overflow flag lost");
    wake_pulse_a: assert property (!trst && (ovf_ev || cmp_ev || cap_ev) |=> wake_r)
        else $error("wake missing");
    reset_load_a: assert property (trst |=> cnt_r == tc_pkg::CNT_ZERO
        && ctrl_r == tc_pkg::CTRL_RST) else $error("reset values wrong");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
endmodule : bidir_timer_counter_pwm
`default_nettype wire

// ### testbench/axil_host.sv
`default_nettype none
module axil_host (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {awvalid, wvalid, arvalid, bready, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end
    // Address and data offered together, each released when taken
    task automatic put(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'h7};
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                {awvalid, awaddr} <= {1'b0, ~a};
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                {wvalid, wdata} <= {1'b0, ~d};
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge aclk); while (arready !== 1'b1);
        {araddr, arvalid} <= {~a, 1'b0};
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : get
endmodule : axil_host
`default_nettype wire

// ### testbench/bidir_timer_counter_pwm_bench.sv
`default_nettype none
module bidir_timer_counter_pwm_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        timer_input_clock = 1'b0;
    logic        timer_reset_low = 1'b1;
    logic        capture_trigger_in = 1'b0;
    logic        timer_interrupt_out, wake_interrupt_out, compare_waveform_out;
    logic [15:0] count_value;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    int          wakes = 0;
    always #2 aclk = ~aclk;
    bidir_timer_counter_pwm u_dut (.*);
    axil_host u_host (.*);
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (wake_interrupt_out === 1'b1) wakes <= wakes + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_host.put(a, d, r);
        cmp(32'(r), 32'(tc_pkg::RESP_OKAY));
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic [31:0] d;
        logic [1:0]  r;
        u_host.get(a, d, r);
        cmp(d, e);
        cmp(32'(r), 32'(er));
    endtask : rdc
    // High samples, output edges and largest count over n edges
    task automatic watch(input int n, output int hi, output int tg, output int mx);
        logic last;
        {hi, tg, mx} = 96'h0;
        last = compare_waveform_out;
        repeat (n) begin
            @(posedge aclk);
            hi += int'(compare_waveform_out === 1'b1);
            tg += int'(compare_waveform_out !== last);
            last = compare_waveform_out;
            if (int'(count_value) > mx) mx = int'(count_value);
        end
    endtask : watch
    task automatic trig();
        capture_trigger_in <= 1'b1;
        repeat (3) @(posedge aclk);
        capture_trigger_in <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : trig
    task automatic t_regs();
        rdc(tc_pkg::OFF_CTRL, 32'h00000400);
        rdc(tc_pkg::OFF_TOP, 32'h0000FFFF);
        rdc(tc_pkg::OFF_CMP, 32'h00008000);
        rdc(8'h20, 32'h00000000, tc_pkg::RESP_SLVERR);
        rdc(8'h06, 32'h00000000, tc_pkg::RESP_SLVERR);
        wr(tc_pkg::OFF_CTRL, 32'h00000144);
        timer_reset_low <= 1'b0;
        repeat (2) @(posedge aclk);
        #1 cmp(32'(count_value), 32'h00000000);
        @(posedge aclk) timer_reset_low <= 1'b1;
        rdc(tc_pkg::OFF_CTRL, 32'h00000400);
        $display("register and reset test done");
    endtask : t_regs
    task automatic t_count();
        wr(tc_pkg::OFF_CTRL, 32'h00000140);
        wr(tc_pkg::OFF_CNT, 32'h00000100);
        wr(tc_pkg::OFF_CTRL, 32'h00000004);
        wr(tc_pkg::OFF_CTRL, 32'h00000144);
        cmp(32'(count_value < 16'h0100 && count_value > 16'h00F0), 32'h1);
        wr(tc_pkg::OFF_CTRL, 32'h00000000);
        wr(tc_pkg::OFF_CTRL, 32'h00000140);
        #1 cmp(32'(count_value), 32'h00000100);
        wr(tc_pkg::OFF_CNT, 32'h00000000);
        wr(tc_pkg::OFF_CTRL, 32'h00000020);
        repeat (5) begin
            @(posedge aclk) timer_input_clock <= 1'b1;
            repeat (2) @(posedge aclk);
            timer_input_clock <= 1'b0;
        end
        repeat (8) @(posedge aclk);
        cmp(32'(count_value), 32'h00000005);
        wr(tc_pkg::OFF_CNT, 32'h00000000);
        wr(tc_pkg::OFF_CTRL, 32'h00000040);
        repeat (80) @(posedge aclk);
        wr(tc_pkg::OFF_CTRL, 32'h00000140);
        cmp(32'(count_value > 16'h0008 && count_value < 16'h000D), 32'h1);
        $display("count test done");
    endtask : t_count
    task automatic t_irq();
        int n;
        wr(tc_pkg::OFF_CTRL, 32'h00000150);
        wr(tc_pkg::OFF_ICLR, 32'h00000007);
        wr(tc_pkg::OFF_CMP, 32'h0000FFF8);
        wr(tc_pkg::OFF_CNT, 32'h0000FFF0);
        n = wakes;
        wr(tc_pkg::OFF_CTRL, 32'h00000010);
        repeat (30) @(posedge aclk);
        wr(tc_pkg::OFF_CTRL, 32'h00000150);
        rdc(tc_pkg::OFF_STAT, 32'h00000003);
        cmp(32'(wakes - n), 32'h00000002);
        cmp(32'(timer_interrupt_out), 32'h0);
        wr(tc_pkg::OFF_CTRL, 32'h00000140);
        repeat (2) @(posedge aclk);
        cmp(32'(timer_interrupt_out), 32'h1);
        wr(tc_pkg::OFF_CTRL, 32'h00000150);
        wr(tc_pkg::OFF_IEN, 32'h00000002);
        repeat (2) @(posedge aclk);
        cmp(32'(timer_interrupt_out), 32'h1);
        wr(tc_pkg::OFF_ICLR, 32'h00000002);
        repeat (2) @(posedge aclk);
        cmp(32'(timer_interrupt_out), 32'h0);
        rdc(tc_pkg::OFF_STAT, 32'h00000001);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_cap();
        wr(tc_pkg::OFF_ICLR, 32'h00000007);
        wr(tc_pkg::OFF_CTRL, 32'h00000158);
        wr(tc_pkg::OFF_CNT, 32'h00000ABC);
        trig();
        rdc(tc_pkg::OFF_CAPT, 32'h00000ABC);
        rdc(tc_pkg::OFF_STAT, 32'h00000004);
        wr(tc_pkg::OFF_CTRL, 32'h0000015A);
        wr(tc_pkg::OFF_CNT, 32'h00000DEF);
        trig();
        rdc(tc_pkg::OFF_CAPT, 32'h00000ABC);
        wr(tc_pkg::OFF_CTRL, 32'h00000148);
        trig();
        rdc(tc_pkg::OFF_CAPT, 32'h00000ABC);
        $display("capture test done");
    endtask : t_cap
    task automatic t_pwm();
        int hi;
        int tg;
        int mx;
        wr(tc_pkg::OFF_CTRL, 32'h00000140);
        wr(tc_pkg::OFF_TOP, 32'h00000009);
        wr(tc_pkg::OFF_CMP, 32'h00000003);
        wr(tc_pkg::OFF_CNT, 32'h00000000);
        wr(tc_pkg::OFF_CTRL, 32'h00000002);
        repeat (20) @(posedge aclk);
        watch(40, hi, tg, mx);
        cmp(hi, 12);
        cmp(mx, 9);
        wr(tc_pkg::OFF_CTRL, 32'h00000202);
        repeat (20) @(posedge aclk);
        watch(40, hi, tg, mx);
        cmp(hi, 28);
        wr(tc_pkg::OFF_CTRL, 32'h00000003);
        repeat (40) @(posedge aclk);
        watch(36, hi, tg, mx);
        cmp(hi, 10);
        wr(tc_pkg::OFF_CTRL, 32'h00000140);
        wr(tc_pkg::OFF_CMP, 32'h00000004);
        wr(tc_pkg::OFF_CNT, 32'h00000000);
        wr(tc_pkg::OFF_CTRL, 32'h00000001);
        repeat (10) @(posedge aclk);
        watch(30, hi, tg, mx);
        cmp(tg, 6);
        cmp(mx, 4);
        $display("waveform test done");
    endtask : t_pwm
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_count();
        t_irq();
        t_cap();
        t_pwm();
        stop_test();
    end
endmodule : bidir_timer_counter_pwm_bench
`default_nettype wire
